// ==== design/smf_top.v ====
// serial message framer: rts sequencing, start break and rx start detect
`timescale 1ns/1ps
`default_nettype none
`include "smf_consts.vh"

module smf_top #(
  parameter [17:0] MS_CYCLES = `SMF_MS_CYCLES
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire irq,
  input wire cts_pin,
  input wire dsr_pin,
  input wire rxd_pin,
  output reg rts_pin,
  output reg dtr_pin,
  output reg txd_force_en,
  output reg txd_force_level,
  output wire send_ready,
  input wire send_done,
  output reg send_abort,
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire rx_msg_end,
  output reg rx_in_msg
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ON = 3'h1;
  localparam [2:0] ST_CTS = 3'h2;
  localparam [2:0] ST_BRK = 3'h3;
  localparam [2:0] ST_MARK = 3'h4;
  localparam [2:0] ST_SEND = 3'h5;
  localparam [2:0] ST_OFF = 3'h6;

  reg ack_q;
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [8:0] ctrl;
  reg [15:0] rts_on;
  reg [15:0] rts_off;
  reg [15:0] cts_wait;
  reg [15:0] brk_bits;
  reg [15:0] tx_idle_bits;
  reg [15:0] rx_idle_bits;
  reg [15:0] bit_div;
  reg [7:0] start_chr;
  reg [5:0] status;
  reg [5:0] mask;
  reg [17:0] ms_cnt;
  reg [15:0] bit_cnt;
  reg [2:0] tx_state;
  reg [15:0] tx_cnt;
  reg [12:0] tx_ms;
  reg [15:0] lo_cnt;
  reg [15:0] hi_cnt;
  reg [12:0] hi_ms;
  reg idle_seen;
  reg [1:0] rx_reason;
  reg [7:0] buf_mem [0:15];
  reg [4:0] wp;
  reg [4:0] rp;
  reg [5:0] tx_set;

  wire wr_acc = avs_write & ack_q;
  wire rd_acc = avs_read & ack_q;
  wire [5:0] widx = avs_address[7:2];
  wire cts_s = sync2[2];
  wire dsr_s = sync2[1];
  wire rxd_s = sync2[0];
  wire rs232 = ctrl[`SMF_C_RS232];
  wire hw = ctrl[`SMF_C_HWFLOW] & rs232;
  wire go = wr_acc & (widx == `SMF_R_CTRL) & avs_writedata[`SMF_C_GO];
  wire ms_tick = (ms_cnt == MS_CYCLES - 18'd1);
  wire bit_tick = ({1'b0, bit_cnt} + 17'd1 >= {1'b0, bit_div});
  wire cap_tx = (tx_ms == `SMF_EIGHT_S_MS);
  wire empty = (wp == rp);
  wire full = (wp[3:0] == rp[3:0]) & (wp[4] != rp[4]);

  // one wait cycle on every access keeps readdata a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign irq = |(status & mask);
  // pause the engine while cts is low under hardware flow control
  assign send_ready = (tx_state == ST_SEND) & (~hw | cts_s);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      sync1 <= 3'h1;
      sync2 <= 3'h1;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      sync1 <= {cts_pin, dsr_pin, rxd_pin};
      sync2 <= sync1;
    end
  end

  // ms tick and bit tick from the system clock
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt <= 18'h00000;
      bit_cnt <= 16'h0000;
    end else begin
      ms_cnt <= ms_tick ? 18'h00000 : ms_cnt + 18'd1;
      bit_cnt <= bit_tick ? 16'h0000 : bit_cnt + 16'd1;
    end
  end

  // settings come back to defaults only through reset
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `SMF_CTRL_RST;
      rts_on <= `SMF_RTS_ON_RST;
      rts_off <= `SMF_RTS_OFF_RST;
      cts_wait <= `SMF_CTS_WAIT_RST;
      brk_bits <= `SMF_BRK_BITS_RST;
      tx_idle_bits <= `SMF_TX_IDLE_RST;
      rx_idle_bits <= `SMF_RX_IDLE_RST;
      bit_div <= `SMF_BIT_DIV_RST;
      start_chr <= `SMF_START_CHR_RST;
      mask <= 6'h00;
    end else if (wr_acc) begin
      case (widx)
        `SMF_R_CTRL: ctrl <= avs_writedata[8:0];
        `SMF_R_RTS_ON: rts_on <= avs_writedata[15:0];
        `SMF_R_RTS_OFF: rts_off <= avs_writedata[15:0];
        `SMF_R_CTS_WAIT: cts_wait <= avs_writedata[15:0];
        `SMF_R_BRK_BITS: brk_bits <= avs_writedata[15:0];
        `SMF_R_TX_IDLE: tx_idle_bits <= avs_writedata[15:0];
        `SMF_R_RX_IDLE: rx_idle_bits <= avs_writedata[15:0];
        `SMF_R_BIT_DIV: bit_div <= avs_writedata[15:0];
        `SMF_R_START_CHR: start_chr <= avs_writedata[7:0];
        `SMF_R_MASK: mask <= avs_writedata[5:0];
        default: mask <= mask;
      endcase
    end
  end

  // transmit sequencer
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= ST_IDLE;
      tx_cnt <= 16'h0000;
      tx_ms <= 13'h0000;
      rts_pin <= 1'b0;
      dtr_pin <= 1'b0;
      txd_force_en <= 1'b0;
      txd_force_level <= 1'b1;
      send_abort <= 1'b0;
      tx_set <= 6'h00;
    end else begin
      send_abort <= 1'b0;
      tx_set <= 6'h00;
      dtr_pin <= hw;
      case (tx_state)
        ST_IDLE: begin
          rts_pin <= hw & ctrl[`SMF_C_RTS_ALWAYS];
          tx_cnt <= 16'h0000;
          tx_ms <= 13'h0000;
          if (go) begin
            if (hw & ~dsr_s) begin
              tx_set[`SMF_S_DSRERR] <= 1'b1;
            end else if (hw) begin
              rts_pin <= 1'b1;
              tx_state <= ST_ON;
            end else if (ctrl[`SMF_C_BRK]) begin
              txd_force_en <= 1'b1;
              txd_force_level <= 1'b0;
              tx_state <= ST_BRK;
            end else begin
              tx_state <= ST_SEND;
            end
          end
        end
        ST_ON: begin
          // cts ignored until the on-delay is over
          if (tx_cnt == rts_on) begin
            tx_cnt <= 16'h0000;
            tx_state <= ST_CTS;
          end else if (ms_tick) begin
            tx_cnt <= tx_cnt + 16'd1;
          end
        end
        ST_CTS: begin
          if (cts_s) begin
            tx_cnt <= 16'h0000;
            if (ctrl[`SMF_C_BRK]) begin
              txd_force_en <= 1'b1;
              txd_force_level <= 1'b0;
              tx_state <= ST_BRK;
            end else begin
              tx_state <= ST_SEND;
            end
          end else if (tx_cnt == cts_wait) begin
            tx_set[`SMF_S_TXERR] <= 1'b1;
            send_abort <= 1'b1;
            rts_pin <= ctrl[`SMF_C_RTS_ALWAYS];
            tx_state <= ST_IDLE;
          end else if (ms_tick) begin
            tx_cnt <= tx_cnt + 16'd1;
          end
        end
        ST_BRK: begin
          if (tx_cnt == brk_bits || cap_tx) begin
            tx_cnt <= 16'h0000;
            tx_ms <= 13'h0000;
            tx_set[`SMF_S_RXBRK] <= 1'b0;
            if (ctrl[`SMF_C_IDLE]) begin
              txd_force_level <= 1'b1;
              tx_state <= ST_MARK;
            end else begin
              txd_force_en <= 1'b0;
              txd_force_level <= 1'b1;
              tx_state <= ST_SEND;
            end
          end else begin
            if (bit_tick) begin
              tx_cnt <= tx_cnt + 16'd1;
            end
            if (ms_tick) begin
              tx_ms <= tx_ms + 13'd1;
            end
          end
        end
        ST_MARK: begin
          if (tx_cnt == tx_idle_bits || cap_tx) begin
            tx_cnt <= 16'h0000;
            txd_force_en <= 1'b0;
            tx_state <= ST_SEND;
          end else begin
            if (bit_tick) begin
              tx_cnt <= tx_cnt + 16'd1;
            end
            if (ms_tick) begin
              tx_ms <= tx_ms + 13'd1;
            end
          end
        end
        ST_SEND: begin
          // a dsr drop here is not looked at
          if (send_done) begin
            tx_set[`SMF_S_TXDONE] <= 1'b1;
            tx_cnt <= 16'h0000;
            tx_state <= hw ? ST_OFF : ST_IDLE;
          end else if (hw & ~cts_s) begin
            if (tx_cnt == cts_wait) begin
              tx_set[`SMF_S_TXERR] <= 1'b1;
              send_abort <= 1'b1;
              rts_pin <= ctrl[`SMF_C_RTS_ALWAYS];
              tx_state <= ST_IDLE;
            end else if (ms_tick) begin
              tx_cnt <= tx_cnt + 16'd1;
            end
          end else begin
            tx_cnt <= 16'h0000;
          end
        end
        ST_OFF: begin
          if (tx_cnt == rts_off) begin
            rts_pin <= ctrl[`SMF_C_RTS_ALWAYS];
            tx_state <= ST_IDLE;
          end else if (ms_tick) begin
            tx_cnt <= tx_cnt + 16'd1;
          end
        end
        default: begin
          tx_state <= ST_IDLE;
        end
      endcase
    end
  end

  // receive start detection
  wire brk_evt = ~rxd_s & bit_tick & (lo_cnt == `SMF_CHAR_BITS);
  wire c_idle = ctrl[`SMF_C_SIDLE] & idle_seen & rx_char_valid;
  wire c_brk = ctrl[`SMF_C_SBRK] & brk_evt;
  wire c_chr = ctrl[`SMF_C_SCHR] & rx_char_valid &
               (rx_char_data == start_chr);
  wire c_any = ctrl[`SMF_C_ANY] & rx_char_valid;
  wire start = ~rx_in_msg & (c_idle | c_brk | c_chr | c_any);
  wire store = rx_char_valid & (rx_in_msg | start);
  wire push = store & ~full;
  wire pop = rd_acc & (widx == `SMF_R_RX_DATA) & ~empty;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
      hi_ms <= 13'h0000;
      idle_seen <= 1'b0;
      rx_in_msg <= 1'b0;
      rx_reason <= 2'h0;
    end else begin
      if (!rxd_s) begin
        hi_cnt <= 16'h0000;
        hi_ms <= 13'h0000;
        if (bit_tick && lo_cnt <= `SMF_CHAR_BITS) begin
          lo_cnt <= lo_cnt + 16'd1;
        end
      end else begin
        lo_cnt <= 16'h0000;
        if (bit_tick && hi_cnt != rx_idle_bits) begin
          hi_cnt <= hi_cnt + 16'd1;
        end
        if (ms_tick && hi_ms != `SMF_EIGHT_S_MS) begin
          hi_ms <= hi_ms + 13'd1;
        end
        if (hi_cnt == rx_idle_bits || hi_ms == `SMF_EIGHT_S_MS) begin
          idle_seen <= 1'b1;
        end
      end
      // a character or break uses up the idle period
      if (rx_char_valid | brk_evt) begin
        idle_seen <= 1'b0;
      end
      if (rx_in_msg & rx_msg_end) begin
        rx_in_msg <= 1'b0;
      end else if (start) begin
        rx_in_msg <= 1'b1;
        if (c_idle) begin
          rx_reason <= 2'h1;
        end else if (c_brk) begin
          rx_reason <= 2'h2;
        end else if (c_chr) begin
          rx_reason <= 2'h3;
        end else begin
          rx_reason <= 2'h0;
        end
      end
    end
  end

  // receive buffer; overflow drops the newest character
  always @(posedge sys_clk) begin
    if (push) begin
      buf_mem[wp[3:0]] <= rx_char_data;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp <= 5'h00;
      rp <= 5'h00;
    end else begin
      if (push) begin
        wp <= wp + 5'd1;
      end
      if (pop) begin
        rp <= rp + 5'd1;
      end
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  wire [5:0] clr = (wr_acc && widx == `SMF_R_STATUS) ?
                   avs_writedata[5:0] : 6'h00;
  wire [5:0] rx_set = {brk_evt, store & full, start, 3'h0};

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= 6'h00;
    end else begin
      status <= (status & ~clr) | tx_set | rx_set;
    end
  end

  // read data captured in the wait cycle
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_q) begin
      case (widx)
        `SMF_R_CTRL: avs_readdata <= {23'h000000, ctrl};
        `SMF_R_RTS_ON: avs_readdata <= {16'h0000, rts_on};
        `SMF_R_RTS_OFF: avs_readdata <= {16'h0000, rts_off};
        `SMF_R_CTS_WAIT: avs_readdata <= {16'h0000, cts_wait};
        `SMF_R_BRK_BITS: avs_readdata <= {16'h0000, brk_bits};
        `SMF_R_TX_IDLE: avs_readdata <= {16'h0000, tx_idle_bits};
        `SMF_R_RX_IDLE: avs_readdata <= {16'h0000, rx_idle_bits};
        `SMF_R_BIT_DIV: avs_readdata <= {16'h0000, bit_div};
        `SMF_R_START_CHR: avs_readdata <= {24'h000000, start_chr};
        `SMF_R_STATUS: avs_readdata <= {26'h0000000, status};
        `SMF_R_MASK: avs_readdata <= {26'h0000000, mask};
        `SMF_R_STATE: avs_readdata <= {16'h0000, 3'h0, wp - rp,
                                       rx_in_msg, rx_reason, rts_pin,
                                       1'b0, tx_state};
        `SMF_R_RX_DATA: avs_readdata <= {23'h000000, ~empty,
                                         empty ? 8'h00 : buf_mem[rp[3:0]]};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== design/smf_consts.vh ====
// constants, offsets and field positions for the serial message framer
`ifndef SMF_CONSTS_VH
`define SMF_CONSTS_VH

// one ms and one 9600 baud bit, counted in 4 ns clock cycles
`define SMF_MS_CYCLES 18'h3d090
`define SMF_EIGHT_S_MS 13'h1f40
`define SMF_BIT_DIV_RST 16'h65b9
`define SMF_CHAR_BITS 16'h000a

// word index of each register, byte address is four times it
`define SMF_R_CTRL 6'h00
`define SMF_R_RTS_ON 6'h01
`define SMF_R_RTS_OFF 6'h02
`define SMF_R_CTS_WAIT 6'h03
`define SMF_R_BRK_BITS 6'h04
`define SMF_R_TX_IDLE 6'h05
`define SMF_R_RX_IDLE 6'h06
`define SMF_R_BIT_DIV 6'h07
`define SMF_R_START_CHR 6'h08
`define SMF_R_STATUS 6'h09
`define SMF_R_MASK 6'h0a
`define SMF_R_STATE 6'h0b
`define SMF_R_RX_DATA 6'h0c

// control bits
`define SMF_C_HWFLOW 0
`define SMF_C_RS232 1
`define SMF_C_RTS_ALWAYS 2
`define SMF_C_BRK 3
`define SMF_C_IDLE 4
`define SMF_C_ANY 5
`define SMF_C_SIDLE 6
`define SMF_C_SBRK 7
`define SMF_C_SCHR 8
`define SMF_C_GO 9
`define SMF_CTRL_RST 9'h022

// status bits
`define SMF_S_TXDONE 0
`define SMF_S_TXERR 1
`define SMF_S_DSRERR 2
`define SMF_S_RXSTART 3
`define SMF_S_RXOVF 4
`define SMF_S_RXBRK 5

`define SMF_RTS_ON_RST 16'h0000
`define SMF_RTS_OFF_RST 16'h0000
`define SMF_CTS_WAIT_RST 16'h03e8
`define SMF_BRK_BITS_RST 16'h000c
`define SMF_TX_IDLE_RST 16'h000c
`define SMF_RX_IDLE_RST 16'h0028
`define SMF_START_CHR_RST 8'h02

`endif

// ==== testbench/smf_properties.sv ====
// port checker for the serial message framer
`timescale 1ns/1ps
`default_nettype none
module smf_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic cts_pin,
  input wire logic rts_pin,
  input wire logic dtr_pin,
  input wire logic txd_force_en,
  input wire logic send_ready,
  input wire logic send_done,
  input wire logic send_abort,
  input wire logic rx_char_valid,
  input wire logic rx_msg_end,
  input wire logic rxd_pin,
  input wire logic rx_in_msg
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  a_send_rts: assert property (send_ready && dtr_pin |-> rts_pin)
    else $error("sending without rts");
  a_send_cts: assert property (
    send_ready && dtr_pin |-> $past(cts_pin, 2))
    else $error("sending without cts");
  a_break_hold: assert property (txd_force_en |-> !send_ready)
    else $error("send open during break or idle");
  a_break_rts: assert property (txd_force_en && dtr_pin |-> rts_pin)
    else $error("break without rts");
  a_done_close: assert property (send_done |=> !send_ready)
    else $error("send still open after done");
  a_abort_rts: assert property (send_abort |=> !rts_pin)
    else $error("rts held after abort");
  a_abort_pulse: assert property (send_abort |=> !send_abort)
    else $error("abort longer than one cycle");
  a_start_char: assert property (
    $rose(rx_in_msg) |-> $past(rx_char_valid) || !$past(rxd_pin, 3))
    else $error("message opened without a character or break");
  a_end_close: assert property (
    rx_msg_end && !rx_char_valid |=> !rx_in_msg)
    else $error("message still open after end");
  c_abort: cover property (send_abort);
  c_break: cover property ($rose(txd_force_en));
  c_rx: cover property ($rose(rx_in_msg));
endmodule
bind smf_top smf_properties chk_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .cts_pin(cts_pin), .rts_pin(rts_pin), .dtr_pin(dtr_pin),
  .txd_force_en(txd_force_en), .send_ready(send_ready),
  .send_done(send_done), .send_abort(send_abort),
  .rx_char_valid(rx_char_valid), .rx_msg_end(rx_msg_end),
  .rxd_pin(rxd_pin), .rx_in_msg(rx_in_msg)
);
`default_nettype wire

// ==== testbench/smf_modem.sv ====
// modem model: answers rts with cts, drives dsr and the rx line
`timescale 1ns/1ps
`default_nettype none
module smf_modem (
  input wire logic sys_clk,
  input wire logic rts_pin,
  input wire logic dsr_on,
  input wire logic cts_mute,
  input wire logic [7:0] cts_lag,
  input wire logic rxd_low,
  output logic cts_pin,
  output logic dsr_pin,
  output logic rxd_pin
);
  logic [7:0] age;
  initial begin
    age = 8'h00;
    cts_pin = 1'b0;
    dsr_pin = 1'b1;
    rxd_pin = 1'b1;
  end
  // cts trails rts by a set lag; mute models a modem that never answers
  always @(posedge sys_clk) begin
    age <= !rts_pin ? 8'h00 : (age == 8'hff) ? age : age + 8'h01;
    cts_pin <= rts_pin && !cts_mute && (age >= cts_lag);
    dsr_pin <= dsr_on;
    rxd_pin <= !rxd_low;
  end
endmodule
`default_nettype wire

// ==== testbench/smf_top_tb.sv ====
// self-checking bench for the serial message framer
`timescale 1ns/1ps
`default_nettype none
module smf_top_tb;
  localparam int MS = 20;
  logic sys_clk, rst_b, avs_read, avs_write, send_done, rx_char_valid;
  logic rx_msg_end, dsr_on, cts_mute, rxd_low;
  logic [7:0] avs_address, rx_char_data, cts_lag;
  logic [31:0] avs_writedata, q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq, cts_pin, dsr_pin, rxd_pin, rts_pin, dtr_pin;
  wire txd_force_en, txd_force_level, send_ready, send_abort, rx_in_msg;
  int fail_count, samples_checked, n;
  // short ms tick keeps the delay scenarios within a few hundred cycles
  smf_top #(.MS_CYCLES(18'd20)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .cts_pin(cts_pin),
    .dsr_pin(dsr_pin), .rxd_pin(rxd_pin), .rts_pin(rts_pin),
    .dtr_pin(dtr_pin), .txd_force_en(txd_force_en),
    .txd_force_level(txd_force_level), .send_ready(send_ready),
    .send_done(send_done), .send_abort(send_abort),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_msg_end(rx_msg_end), .rx_in_msg(rx_in_msg)
  );
  smf_modem modem (
    .sys_clk(sys_clk), .rts_pin(rts_pin), .dsr_on(dsr_on),
    .cts_mute(cts_mute), .cts_lag(cts_lag), .rxd_low(rxd_low),
    .cts_pin(cts_pin),
    .dsr_pin(dsr_pin), .rxd_pin(rxd_pin)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  function logic sig(input int k);
    case (k)
      0: sig = rts_pin;
      1: sig = send_ready;
      2: sig = txd_force_en;
      3: sig = send_abort;
      4: sig = txd_force_level;
      default: sig = rx_in_msg;
    endcase
  endfunction
  // counts edges until the output takes the value; bounded
  task wt(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task pulse(input logic c, input logic [7:0] d);
    rx_char_data <= d;
    rx_char_valid <= c;
    send_done <= !c;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
    send_done <= 1'b0;
    @(posedge sys_clk);
  endtask
  task do_reset;
    rst_b <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
  endtask
  task t_defaults;
    logic [31:0] dv [9];
    dv = '{32'h22, 32'h0, 32'h0, 32'h3e8, 32'hc, 32'hc, 32'h28,
      32'h65b9, 32'h2};
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'hffff, dv[i]);
    wr(8'h3c, 32'hff);
    rd(8'h3c, 32'hffffffff, 32'h0);
  endtask
  task t_rx_any;
    pulse(1'b1, 8'h55);
    chk(rx_in_msg, 1'b1);
    pulse(1'b1, 8'h66);
    rd(8'h30, 32'h1ff, 32'h155);
    rd(8'h30, 32'h1ff, 32'h166);
    rd(8'h30, 32'h100, 32'h0);
    rx_msg_end <= 1'b1;
    @(posedge sys_clk);
    rx_msg_end <= 1'b0;
    @(posedge sys_clk);
    chk(rx_in_msg, 1'b0);
  endtask
  task t_hw_send;
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h3);
    wr(8'h0c, 32'h1);
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h2);
    wr(8'h1c, 32'h4);
    cts_lag <= 8'd30;
    // go acts on the control word held before its own write
    wr(8'h00, 32'h03b);
    wr(8'h00, 32'h23b);
    wt(0, 1'b1, 10);
    wt(2, 1'b1, 5 * MS);
    chk(n >= 2 * MS, 1'b1);
    chk(txd_force_level, 1'b0);
    wt(4, 1'b1, 40);
    chk(n >= 8 && n <= 13, 1'b1);
    wt(2, 1'b0, 40);
    chk(n >= 4 && n <= 9, 1'b1);
    wt(1, 1'b1, 20);
    pulse(1'b0, 8'h0);
    wt(0, 1'b0, 5 * MS);
    chk(n >= 2 * MS - 2, 1'b1);
    // cts came inside the on-delay, so a wait timed from rts would abort
    rd(8'h24, 32'h7, 32'h1);
    wr(8'h28, 32'h1);
    chk(irq, 1'b1);
    wr(8'h24, 32'h1);
    chk(irq, 1'b0);
    wr(8'h28, 32'h0);
  endtask
  task t_soft;
    logic [31:0] cv [2];
    cv = '{32'h222, 32'h221};
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, cv[i] & 32'h1ff);
      wr(8'h00, cv[i]);
      wt(1, 1'b1, 20);
      chk({rts_pin, dtr_pin}, 2'b00);
      pulse(1'b0, 8'h0);
    end
  endtask
  task t_abort;
    wr(8'h24, 32'h3f);
    cts_mute <= 1'b1;
    wr(8'h00, 32'h023);
    wr(8'h00, 32'h223);
    wt(3, 1'b1, 10 * MS);
    chk(n >= MS, 1'b1);
    @(posedge sys_clk);
    chk(rts_pin, 1'b0);
    rd(8'h24, 32'h2, 32'h2);
    cts_mute <= 1'b0;
  endtask
  task t_dsr;
    wr(8'h24, 32'h3f);
    dsr_on <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(8'h00, 32'h223);
    repeat (8) @(posedge sys_clk);
    chk(rts_pin, 1'b0);
    rd(8'h24, 32'h4, 32'h4);
    dsr_on <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(8'h00, 32'h223);
    wt(1, 1'b1, 8 * MS);
    dsr_on <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(send_ready, 1'b1);
    pulse(1'b0, 8'h0);
    wt(0, 1'b0, 8 * MS);
  endtask
  task t_rx_line;
    wr(8'h18, 32'h5);
    wr(8'h00, 32'h0c2);
    rxd_low <= 1'b1;
    // exactly one character time low is not yet a break
    repeat (40) @(posedge sys_clk);
    chk(rx_in_msg, 1'b0);
    wt(5, 1'b1, 20);
    rd(8'h2c, 32'h60, 32'h40);
    rd(8'h24, 32'h20, 32'h20);
    rxd_low <= 1'b0;
    rx_msg_end <= 1'b1;
    @(posedge sys_clk);
    rx_msg_end <= 1'b0;
    pulse(1'b1, 8'h30);
    chk(rx_in_msg, 1'b0);
    repeat (40) @(posedge sys_clk);
    pulse(1'b1, 8'h30);
    chk(rx_in_msg, 1'b1);
    rd(8'h2c, 32'h60, 32'h20);
    rx_msg_end <= 1'b1;
    @(posedge sys_clk);
    rx_msg_end <= 1'b0;
    @(posedge sys_clk);
  endtask
  task t_rx_char;
    wr(8'h20, 32'h41);
    wr(8'h00, 32'h102);
    pulse(1'b1, 8'h30);
    chk(rx_in_msg, 1'b0);
    pulse(1'b1, 8'h41);
    chk(rx_in_msg, 1'b1);
    rd(8'h2c, 32'h60, 32'h60);
  endtask
  initial begin
    fail_count = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    send_done = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
    rx_msg_end = 1'b0;
    dsr_on = 1'b1;
    cts_mute = 1'b0;
    cts_lag = 8'd0;
    rxd_low = 1'b0;
    do_reset();
    t_defaults();
    t_rx_any();
    t_hw_send();
    t_soft();
    t_abort();
    t_dsr();
    t_rx_line();
    t_rx_char();
    do_reset();
    t_defaults();
    tally_and_finish();
  end
endmodule
`default_nettype wire
